// [hdl/instruction_phase_pipeline.sv]
// four-phase instruction sequencer with overlapped fetch and 8-bit execute
//
// Functional notes
// - four non-overlapping phases per instruction cycle
// - phase one increments pc and fetches next
// - phases two to four decode and execute
// - one four-phase pass is one cycle
// - fetch overlaps execute, one instruction per cycle
// - pc load costs one extra cycle
// - wake-up delay depends on clock source
// - both slow sources off gives 1024 delay
// - execute uses an 8-bit arithmetic unit
// - data path runs through accumulator and unit
// - taken skip discards prefetched word, dummy cycle
// - reset loads pc zero, fetch begins there
`timescale 1ns/1ps
module instruction_phase_pipeline
  import phase_pipeline_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire clock_source_e clock_source,
  input wire logic slow_crystal_enable,
  input wire logic internal_slow_enable,
  input wire logic halt_request,
  input wire logic wake_request,
  input wire logic [INSN_WIDTH-1:0] fetch_data,
  input wire alu_op_e decoded_op,
  input wire logic [7:0] operand,
  input wire logic [PC_WIDTH-1:0] branch_target,
  output logic [3:0] instruction_phase_clocks,
  output logic [PC_WIDTH-1:0] fetch_address,
  output logic fetch_strobe,
  output logic [INSN_WIDTH-1:0] current_insn,
  output logic execute_valid,
  output logic dummy_cycle,
  output logic [7:0] accumulator,
  output logic zero_flag,
  output logic carry_flag,
  output logic halted
);

  typedef struct packed {
    logic [3:0] phase;
    logic [PC_WIDTH-1:0] pc;
    logic [INSN_WIDTH-1:0] fetched;
    logic [INSN_WIDTH-1:0] insn;
    logic insn_valid;
    logic flush;
    logic [7:0] acc;
    logic zero;
    logic carry;
    logic [10:0] wait_count;
    run_state_e state;
    logic strobe;
    logic exec;
    logic dummy;
  } pipe_s;

  pipe_s cur;
  pipe_s next_cur;

  // startup count for the selected source, slow sources off forces long wait
  function automatic logic [10:0] startup_count(
    input clock_source_e src,
    input logic slow_xtal_on,
    input logic slow_osc_on
  );
    logic [10:0] count;
    count = STARTUP_SLOW_COUNT;
    if (!slow_xtal_on && !slow_osc_on)
    begin
      count = STARTUP_SLOW_COUNT;
    end
    else
    begin
      unique case (src)
        src_fast_crystal:
        begin
          count = STARTUP_SLOW_COUNT;
        end
        src_slow_crystal:
        begin
          count = STARTUP_SLOW_COUNT;
        end
        src_external_rc:
        begin
          count = STARTUP_FAST_COUNT;
        end
        src_internal_fast:
        begin
          count = STARTUP_FAST_COUNT;
        end
        src_internal_slow:
        begin
          count = STARTUP_SLOW_OSC_COUNT;
        end
        default:
        begin
          // unused source codes take the safe long wait
          count = STARTUP_SLOW_COUNT;
        end
      endcase
    end
    return count;
  endfunction : startup_count

  logic [8:0] alu_result;
  logic skip_taken;
  logic branch_taken;
  logic [3:0] phase_rotated;

  // each phase hands over to the next, phase four wraps to phase one
  for (genvar i = 0; i < 4; i++)
  begin : g_phase_ring
    assign phase_rotated[i] = cur.phase[(i + 3) % 4];
  end

  // 8-bit arithmetic unit fed from the accumulator
  always_comb
  begin
    alu_result = {1'b0, cur.acc};
    skip_taken = 1'b0;
    branch_taken = 1'b0;
    unique case (decoded_op)
      op_nop:
      begin
        alu_result = {1'b0, cur.acc};
      end
      op_add:
      begin
        alu_result = {1'b0, cur.acc} + {1'b0, operand};
      end
      op_sub:
      begin
        alu_result = {1'b0, cur.acc} - {1'b0, operand};
      end
      op_and:
      begin
        alu_result = {1'b0, cur.acc & operand};
      end
      op_or:
      begin
        alu_result = {1'b0, cur.acc | operand};
      end
      op_xor:
      begin
        alu_result = {1'b0, cur.acc ^ operand};
      end
      op_cpl:
      begin
        alu_result = {1'b0, ~cur.acc};
      end
      op_rl:
      begin
        // carry takes the bit that wraps round
        alu_result = {cur.acc[7], cur.acc[6:0], cur.acc[7]};
      end
      op_rr:
      begin
        alu_result = {cur.acc[0], cur.acc[0], cur.acc[7:1]};
      end
      op_inc:
      begin
        alu_result = {1'b0, cur.acc} + 9'h001;
      end
      op_dec:
      begin
        alu_result = {1'b0, cur.acc} - 9'h001;
      end
      op_load:
      begin
        alu_result = {1'b0, operand};
      end
      op_jump:
      begin
        branch_taken = 1'b1;
      end
      op_skip_zero:
      begin
        skip_taken = (operand == 8'h00);
      end
      op_skip_nonzero:
      begin
        skip_taken = (operand != 8'h00);
      end
      default:
      begin
        // undefined codes leave the accumulator alone
        alu_result = {1'b0, cur.acc};
      end
    endcase
  end

  always_comb
  begin
    next_cur = cur;
    next_cur.strobe = 1'b0;
    next_cur.exec = 1'b0;
    next_cur.dummy = 1'b0;
    unique case (cur.state)
      st_run:
      begin
        // rotate one-hot phase, one pass is one instruction cycle
        next_cur.phase = phase_rotated;
        if (cur.phase[0])
        begin
          // fetch word from pc, then step pc while the held word executes
          next_cur.fetched = fetch_data;
          next_cur.pc = cur.pc + 11'h001;
          next_cur.strobe = 1'b1;
        end
        if (cur.phase[3])
        begin
          // the word fetched this cycle becomes next cycle's instruction
          next_cur.insn = cur.fetched;
          next_cur.insn_valid = ~cur.flush;
          next_cur.flush = 1'b0;
          next_cur.dummy = cur.flush;
          if (cur.insn_valid)
          begin
            next_cur.exec = 1'b1;
            if (branch_taken)
            begin
              // prefetched word is stale, so a dummy cycle follows
              next_cur.pc = branch_target;
              next_cur.insn_valid = 1'b0;
              next_cur.dummy = 1'b1;
            end
            else if (skip_taken)
            begin
              next_cur.insn_valid = 1'b0;
              next_cur.dummy = 1'b1;
            end
            else if (decoded_op != op_nop)
            begin
              next_cur.acc = alu_result[7:0];
              next_cur.zero = (alu_result[7:0] == 8'h00);
              next_cur.carry = alu_result[8];
            end
          end
          if (halt_request)
          begin
            // stop on an instruction boundary only
            next_cur.state = st_halt;
            next_cur.phase = PHASE_RESET;
          end
        end
      end
      st_halt:
      begin
        next_cur.phase = PHASE_RESET;
        if (wake_request)
        begin
          next_cur.state = st_startup;
          next_cur.wait_count = startup_count(clock_source,
            slow_crystal_enable, internal_slow_enable);
        end
      end
      st_startup:
      begin
        next_cur.phase = PHASE_RESET;
        // the count includes this cycle, resuming in phase one
        if (cur.wait_count <= 11'h001)
        begin
          next_cur.state = st_run;
          next_cur.wait_count = 11'h000;
        end
        else
        begin
          next_cur.wait_count = cur.wait_count - 11'h001;
        end
      end
      default: next_cur.state = st_run;
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      cur.phase <= PHASE_RESET;
      cur.pc <= PC_RESET;
      cur.fetched <= '0;
      cur.insn <= '0;
      cur.insn_valid <= 1'b0;
      cur.flush <= 1'b0;
      cur.acc <= 8'h00;
      cur.zero <= 1'b0;
      cur.carry <= 1'b0;
      cur.wait_count <= 11'h000;
      cur.state <= st_run;
      cur.strobe <= 1'b0;
      cur.exec <= 1'b0;
      cur.dummy <= 1'b0;
    end
    else
    begin
      cur <= next_cur;
    end
  end

  // phases stay low while halted or waking so no stage advances
  assign instruction_phase_clocks = (cur.state == st_run) ? cur.phase : 4'h0;
  assign fetch_address = cur.pc;
  assign fetch_strobe = cur.strobe;
  assign current_insn = cur.insn;
  assign execute_valid = cur.exec;
  assign dummy_cycle = cur.dummy;
  assign accumulator = cur.acc;
  assign zero_flag = cur.zero;
  assign carry_flag = cur.carry;
  assign halted = (cur.state != st_run);

endmodule : instruction_phase_pipeline

// [hdl/phase_pipeline_pkg.sv]
// shared constants and types for the instruction phase pipeline
package phase_pipeline_pkg;
  localparam int PC_WIDTH = 11;
  localparam int INSN_WIDTH = 16;
  localparam logic [10:0] PC_RESET = 11'h000;
  localparam logic [10:0] STARTUP_SLOW_COUNT = 11'h400;
  localparam logic [10:0] STARTUP_FAST_COUNT = 11'h010;
  localparam logic [10:0] STARTUP_SLOW_OSC_COUNT = 11'h002;
  localparam logic [3:0] PHASE_RESET = 4'h1;
  // operation codes presented by the decoder
  typedef enum logic [3:0] {
    op_nop = 4'h0,
    op_add = 4'h1,
    op_sub = 4'h2,
    op_and = 4'h3,
    op_or = 4'h4,
    op_xor = 4'h5,
    op_cpl = 4'h6,
    op_rl = 4'h7,
    op_rr = 4'h8,
    op_inc = 4'h9,
    op_dec = 4'hA,
    op_load = 4'hB,
    op_jump = 4'hC,
    op_skip_zero = 4'hD,
    op_skip_nonzero = 4'hE
  } alu_op_e;
  // clock source selection
  typedef enum logic [2:0] {
    src_fast_crystal = 3'h0,
    src_slow_crystal = 3'h1,
    src_external_rc = 3'h2,
    src_internal_fast = 3'h3,
    src_internal_slow = 3'h4
  } clock_source_e;
  typedef enum logic [1:0] {
    st_run = 2'h0,
    st_halt = 2'h1,
    st_startup = 2'h2
  } run_state_e;
endpackage : phase_pipeline_pkg

// [testbench/phase_monitor.sv]
// concurrent checks on the phase pipeline ports
`timescale 1ns/1ps
module phase_monitor
  import phase_pipeline_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [3:0] instruction_phase_clocks,
  input wire logic [PC_WIDTH-1:0] fetch_address,
  input wire logic fetch_strobe,
  input wire logic execute_valid,
  input wire logic dummy_cycle,
  input wire logic [7:0] accumulator,
  input wire logic halted
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  wire logic [3:0] p = instruction_phase_clocks;
  wire logic early = p == 4'h1 || p == 4'h2 || p == 4'h4;
  phase_onehot_a: assert property (!halted |-> $onehot(p))
    else $error("phase not one-hot");
  phase_order_a: assert property (
    early |=> p == {$past(p[2:0]), 1'b0}) else $error("phase order");
  pc_step_a: assert property (
    p == 4'h1 |=> fetch_address == $past(fetch_address) + 1'b1)
    else $error("pc step");
  fetch_strobe_a: assert property (
    p == 4'h1 |=> fetch_strobe && p == 4'h2) else $error("fetch strobe");
  acc_window_a: assert property (early |=> $stable(accumulator))
    else $error("acc outside execute");
  result_phase_a: assert property (
    (execute_valid || dummy_cycle) && !halted |-> p == 4'h1)
    else $error("result phase");
  halted_phase_a: assert property (halted |-> p == 4'h0)
    else $error("phase while halted");
  dummy_drop_a: assert property (dummy_cycle |-> ##4 !execute_valid)
    else $error("dummy executed");
  reset_start_a: assert property (disable iff (1'b0)
    $fell(rst) |-> p == 4'h1 && fetch_address == 11'h000)
    else $error("reset start");
endmodule : phase_monitor

// [testbench/tb.sv]
// self-checking bench for the instruction phase pipeline
`timescale 1ns/1ps
module tb;
  import phase_pipeline_pkg::*;
  logic sys_clk = 1'b0, rst = 1'b1, halt_request = 1'b0;
  logic wake_request = 1'b0, slow_crystal_enable = 1'b1;
  logic internal_slow_enable = 1'b1;
  clock_source_e clock_source = src_fast_crystal;
  alu_op_e decoded_op = op_nop;
  logic [7:0] operand = 8'h00, acc;
  logic [10:0] branch_target = 11'h000, pc;
  logic [15:0] fetch_data, current_insn;
  logic [3:0] ph;
  logic fetch_strobe, execute_valid, dummy_cycle, zero_flag;
  logic carry_flag, halted;
  int fail_count = 0, comparisons = 0;
  // memory stand-in: each word carries its own address
  assign fetch_data = {5'h1A, pc};
  instruction_phase_pipeline instruction_phase_pipeline_inst (.sys_clk, .rst,
    .clock_source, .slow_crystal_enable, .internal_slow_enable, .halt_request,
    .wake_request, .fetch_data, .decoded_op, .operand, .branch_target,
    .instruction_phase_clocks(ph), .fetch_address(pc), .fetch_strobe,
    .current_insn, .execute_valid, .dummy_cycle, .accumulator(acc),
    .zero_flag, .carry_flag, .halted);
  initial forever #2.5 sys_clk = ~sys_clk;
  task chk(string n, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task conclude;
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude
  task tick;
    @(posedge sys_clk);
    #1;
  endtask : tick
  task wait_ph(logic [3:0] w);
    for (int i = 0; i < 20 && ph !== w; i++)
      tick();
    chk("phase", w, ph);
    if (ph !== w)
      conclude();
  endtask : wait_ph
  // op is presented for the phase-4 cycle only, as the decoder would
  task exec(alu_op_e op, logic [7:0] v, logic [10:0] t);
    wait_ph(4'h4);
    @(posedge sys_clk);
    decoded_op <= op;
    operand <= v;
    branch_target <= t;
    @(posedge sys_clk);
    decoded_op <= op_nop;
    #1;
  endtask : exec
  task reset_walk;
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    chk("pc", 11'h000, pc);
    tick();
    chk("strobe", 1'b1, fetch_strobe);
    repeat (3) tick();
    chk("insn", 16'hD000, current_insn);
    exec(op_nop, 8'h00, 11'h000);
    chk("valid", 1'b1, execute_valid);
  endtask : reset_walk
  task alu_run;
    alu_op_e o[12] = '{op_load, op_add, op_rl, op_rr, op_inc, op_dec,
      op_load, op_and, op_or, op_xor, op_cpl, op_sub};
    logic [7:0] v[12] = '{8'h80, 8'h80, 8'h00, 8'h00, 8'h00, 8'h00, 8'hF0,
      8'h3C, 8'h0F, 8'hFF, 8'h00, 8'h0F};
    logic [7:0] e[12] = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'hF0,
      8'h30, 8'h3F, 8'hC0, 8'h3F, 8'h30};
    logic [10:0] a;
    a = pc;
    for (int i = 0; i < 12; i++)
    begin
      exec(o[i], v[i], 11'h000);
      chk("acc", e[i], acc);
      chk("zero", e[i] == 8'h00, zero_flag);
      chk("pc", a + 11'h001, pc);
      a = pc;
      if (o[i] == op_add)
        chk("carry", 1'b1, carry_flag);
    end
  endtask : alu_run
  task branch_run;
    exec(op_jump, 8'h00, 11'h123);
    chk("dummy", 1'b1, dummy_cycle);
    chk("target", 11'h123, pc);
    exec(op_load, 8'h77, 11'h000);
    chk("dropped", 8'h30, acc);
    exec(op_skip_zero, 8'h05, 11'h000);
    chk("kept", 1'b0, dummy_cycle);
    exec(op_skip_nonzero, 8'h05, 11'h000);
    chk("skip", 1'b1, dummy_cycle);
    exec(op_load, 8'h77, 11'h000);
    chk("skipped", 8'h30, acc);
  endtask : branch_run
  task sleep(clock_source_e s, logic l, logic r, int n);
    int c;
    wait_ph(4'h4);
    @(posedge sys_clk);
    clock_source <= s;
    slow_crystal_enable <= l;
    internal_slow_enable <= r;
    halt_request <= 1'b1;
    @(posedge sys_clk);
    halt_request <= 1'b0;
    @(posedge sys_clk);
    wake_request <= 1'b1;
    @(posedge sys_clk);
    wake_request <= 1'b0;
    #1;
    for (c = 0; c < 1100 && halted === 1'b1; c++)
      tick();
    chk("startup", 1'b1, c + 1 >= n && c <= n + 2);
  endtask : sleep
  initial
  begin
    reset_walk();
    alu_run();
    branch_run();
    sleep(src_fast_crystal, 1'b1, 1'b1, 1024);
    sleep(src_external_rc, 1'b1, 1'b1, 16);
    sleep(src_internal_slow, 1'b1, 1'b1, 2);
    sleep(src_internal_fast, 1'b0, 1'b0, 1024);
    conclude();
  end
endmodule : tb
bind instruction_phase_pipeline phase_monitor phase_monitor_inst (.sys_clk,
  .rst, .instruction_phase_clocks, .fetch_address, .fetch_strobe,
  .execute_valid, .dummy_cycle, .accumulator, .halted);
